/* core/tecc_pkg.sv */
// Constants for the tag ECC error detail packer
package tecc_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_CAUSE_LO = 4'h0;
  localparam logic [3:0] ADDR_CAUSE_HI = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'hc;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h8;
  // Field positions
  localparam int POS_CLASS   = 58;
  localparam int POS_ARRAY   = 57;
  localparam int POS_WAY     = 29;
  localparam int POS_BANK    = 28;
  localparam int POS_REQ     = 22;
  localparam int POS_HART    = 18;
  localparam int POS_CMD     = 14;
  localparam int POS_GROUP   = 11;
  localparam int POS_ATTR    = 8;
  localparam int POS_SIZE    = 5;
  localparam int POS_TTYPE   = 1;
  localparam int POS_SCHED   = 0;
  // Error classes
  localparam logic [5:0] CLASS_NONE = 6'h00;
  localparam logic [5:0] CLASS_CORR = 6'h01;
  localparam logic [5:0] CLASS_UNCR = 6'h03;
  // Command groups
  localparam logic [2:0] GRP_NORMAL   = 3'h0;
  localparam logic [2:0] GRP_REGS     = 3'h1;
  localparam logic [2:0] GRP_GLOBAL   = 3'h2;
  localparam logic [2:0] GRP_RESERVED = 3'h3;
  localparam logic [2:0] GRP_L1I      = 3'h4;
  localparam logic [2:0] GRP_L1D      = 3'h5;
  localparam logic [2:0] GRP_L3       = 3'h6;
  localparam logic [2:0] GRP_L2       = 3'h7;
  // Reserved size codes and the 64-byte code they are recorded as
  localparam logic [2:0] SIZE_RSV_32  = 3'h5;
  localparam logic [2:0] SIZE_RSV_128 = 3'h7;
  localparam logic [2:0] SIZE_64      = 3'h6;
  // Build configuration
  localparam logic [5:0] NUM_CORES      = 6'h06;
  localparam bit         TWO_SCHEDULERS = 1'b1;
  // Reset values
  localparam logic [63:0] CAUSE_RST = 64'h0;
  localparam logic [1:0]  IRQ_RST   = 2'h0;
  // Interrupt status bits
  localparam int IRQ_CORR = 0;
  localparam int IRQ_UNCR = 1;
endpackage

/* core/tecc_packer.sv */
// Tag ECC error capture register with detail packing and Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module tecc_packer
  import tecc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        err_valid,
  input  wire logic        err_uncorrected,
  input  wire logic        err_in_data,
  input  wire logic [3:0]  err_way,
  input  wire logic        err_bank,
  input  wire logic        err_from_io_unit,
  input  wire logic [5:0]  err_req_index,
  input  wire logic [1:0]  err_hart,
  input  wire logic [3:0]  err_cmd,
  input  wire logic [2:0]  err_group,
  input  wire logic [2:0]  err_attr,
  input  wire logic [2:0]  err_size,
  input  wire logic [3:0]  err_ttype,
  input  wire logic        err_sched,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  // Register map: 0x0 cause low word, 0x4 cause high word with the class
  // in bits 31:26 (writing the current class clears the capture), 0x8
  // status read and write-one-to-clear, 0xc interrupt enable
  typedef enum logic [2:0] {
    TECC_IDLE = 3'b001,
    TECC_RD   = 3'b010,
    TECC_WR   = 3'b100
  } tecc_bus_t;

  // Transfer size code; reserved codes recorded as 64 bytes
  function automatic logic [2:0] tecc_size(input logic [2:0] s);
    logic [2:0] r;
    r = s;
    case (s)
      SIZE_RSV_32: begin
        r = SIZE_64;
      end
      SIZE_RSV_128: begin
        r = SIZE_64;
      end
      default: begin
        r = s;
      end
    endcase
    return r;
  endfunction

  // Command group table; the reserved code is recorded as normal access
  function automatic logic [2:0] tecc_group(input logic [2:0] g);
    logic [2:0] r;
    r = GRP_NORMAL;
    case (g)
      GRP_NORMAL: begin
        r = GRP_NORMAL;
      end
      GRP_REGS: begin
        r = GRP_REGS;
      end
      GRP_GLOBAL: begin
        r = GRP_GLOBAL;
      end
      GRP_RESERVED: begin
        r = GRP_NORMAL;
      end
      GRP_L1I: begin
        r = GRP_L1I;
      end
      GRP_L1D: begin
        r = GRP_L1D;
      end
      GRP_L3: begin
        r = GRP_L3;
      end
      GRP_L2: begin
        r = GRP_L2;
      end
      default: begin
        r = GRP_NORMAL;
      end
    endcase
    return r;
  endfunction

  // I/O units take the codes directly after the last core
  function automatic logic [5:0] tecc_req(input logic       io,
                                          input logic [5:0] idx);
    logic [5:0] r;
    r = idx;
    if (io) begin
      r = 6'(NUM_CORES + idx);
    end
    return r;
  endfunction

  // Register select, one flag per mapped offset
  function automatic logic [3:0] tecc_decode(input logic [3:0] a);
    logic [3:0] s;
    s = 4'h0;
    if (a == ADDR_CAUSE_LO) begin
      s[0] = 1'b1;
    end else if (a == ADDR_CAUSE_HI) begin
      s[1] = 1'b1;
    end else if (a == ADDR_IRQ_STAT) begin
      s[2] = 1'b1;
    end else if (a == ADDR_IRQ_EN) begin
      s[3] = 1'b1;
    end
    return s;
  endfunction

  // Class code of a cache ECC event
  function automatic logic [5:0] tecc_class(input logic uncorrected);
    logic [5:0] c;
    c = CLASS_CORR;
    if (uncorrected) begin
      c = CLASS_UNCR;
    end
    return c;
  endfunction

  // Empty slot or a corrected error may be overwritten
  function automatic logic tecc_overwritable(input logic [5:0] c);
    logic ok;
    ok = 1'b0;
    if (c == CLASS_NONE || c == CLASS_CORR) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Register state
  logic [5:0]  class_r;
  logic [5:0]  class_nxt;
  logic [57:0] info_r;
  logic [57:0] info_nxt;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  en_r;
  logic [1:0]  en_nxt;
  logic        irq_r;
  logic        irq_nxt;
  tecc_bus_t   bus_r;
  tecc_bus_t   bus_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wait_r;
  logic        wait_nxt;

  // Detail assembly and control
  logic [57:0] detail;
  logic [5:0]  err_class;
  logic [5:0]  req_code;
  logic [2:0]  group_code;
  logic [2:0]  size_code;
  logic [3:0]  hart_code;
  logic        sched_bit;
  logic [15:0] way_hot;
  logic [1:0]  stat_set;
  logic [3:0]  wr_sel;
  logic [3:0]  rd_sel;
  logic        slot_free;
  logic        capture;
  logic        sw_clear;
  logic        wr_acc;
  logic        rd_acc;

  // One flag per way, way 0 in the lowest bit
  for (genvar w = 0; w < 16; w++) begin : g_way
    assign way_hot[w] = (err_way == 4'(w));
  end

  // Each event class sets its own sticky status bit
  assign stat_set[IRQ_CORR] = err_valid && !err_uncorrected;
  assign stat_set[IRQ_UNCR] = err_valid && err_uncorrected;

  // Detail field assembly for the tag-error layout
  always_comb begin
    req_code   = tecc_req(err_from_io_unit, err_req_index);
    group_code = tecc_group(err_group);
    size_code  = tecc_size(err_size);
    hart_code  = {2'b00, err_hart};
    sched_bit  = TWO_SCHEDULERS & err_sched;
    err_class  = tecc_class(err_uncorrected);
    detail     = '0;
    detail[POS_ARRAY]      = err_in_data;
    detail[POS_WAY +: 16]  = way_hot;
    detail[POS_BANK]       = err_bank;
    detail[POS_REQ +: 6]   = req_code;
    detail[POS_HART +: 4]  = hart_code;
    detail[POS_CMD +: 4]   = err_cmd;
    detail[POS_GROUP +: 3] = group_code;
    detail[POS_ATTR +: 3]  = err_attr;
    detail[POS_SIZE +: 3]  = size_code;
    detail[POS_TTYPE +: 4] = err_ttype;
    detail[POS_SCHED]      = sched_bit;
  end

  assign slot_free = tecc_overwritable(class_r);
  assign capture   = err_valid && slot_free;
  // Writes land at the edge that samples waitrequest low
  assign wr_acc    = avs_write && (bus_r == TECC_WR);
  assign rd_acc    = avs_read && (bus_r == TECC_IDLE);
  assign wr_sel    = wr_acc ? tecc_decode(avs_address) : 4'h0;
  assign rd_sel    = tecc_decode(avs_address);
  assign sw_clear  = wr_sel[1] && (avs_writedata[31:26] == class_r);

  // Error class; a capture wins over a software clear
  always_comb begin
    class_nxt = class_r;
    if (sw_clear) begin
      class_nxt = CAUSE_RST[63:58];
    end
    if (capture) begin
      class_nxt = err_class;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      class_r <= CAUSE_RST[63:58];
    end else begin
      class_r <= class_nxt;
    end
  end

  // Detail field, rewritten with every capture
  always_comb begin
    info_nxt = info_r;
    if (sw_clear) begin
      info_nxt = CAUSE_RST[57:0];
    end
    if (capture) begin
      info_nxt = detail;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      info_r <= CAUSE_RST[57:0];
    end else begin
      info_r <= info_nxt;
    end
  end

  // Sticky status, write one to clear, a new event wins
  always_comb begin
    stat_nxt = stat_r;
    if (wr_sel[2]) begin
      stat_nxt = stat_r & ~avs_writedata[1:0];
    end
    stat_nxt = stat_nxt | stat_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_r <= IRQ_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Interrupt enable
  always_comb begin
    en_nxt = en_r;
    if (wr_sel[3]) begin
      en_nxt = avs_writedata[1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_r <= IRQ_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // Level interrupt from the next status and enable values
  always_comb begin
    irq_nxt = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Bus handshake: take in IDLE, answer for one cycle, then idle again
  always_comb begin
    bus_nxt  = bus_r;
    wait_nxt = 1'b1;
    case (bus_r)
      TECC_IDLE: begin
        if (avs_read) begin
          bus_nxt  = TECC_RD;
          wait_nxt = 1'b0;
        end else if (avs_write) begin
          bus_nxt  = TECC_WR;
          wait_nxt = 1'b0;
        end
      end
      TECC_RD: begin
        bus_nxt = TECC_IDLE;
      end
      TECC_WR: begin
        bus_nxt = TECC_IDLE;
      end
      default: begin
        bus_nxt = TECC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_r  <= TECC_IDLE;
      wait_r <= 1'b1;
    end else begin
      bus_r  <= bus_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Read data latched when a read is taken, held until the next one
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_acc) begin
      if (rd_sel[0]) begin
        rdata_nxt = info_r[31:0];
      end else if (rd_sel[1]) begin
        rdata_nxt = {class_r, info_r[57:32]};
      end else if (rd_sel[2]) begin
        rdata_nxt = {30'h0, stat_r};
      end else if (rd_sel[3]) begin
        rdata_nxt = {30'h0, en_r};
      end else begin
        rdata_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from registers
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq             = irq_r;

endmodule
`default_nettype wire

/* tb/tecc_err_src.sv */
// Error source model standing in for cores, I/O units and pipeline
`timescale 1ns/1ps
`default_nettype none
module tecc_err_src (
  input  wire logic        core_clk,
  output logic             err_valid,
  output logic [33:0]      err_f
);
  initial begin
    err_valid = 1'b0;
    err_f     = 34'h0;
  end
  task automatic fire(input logic [33:0] f);
    @(posedge core_clk);
    err_f     <= f;
    err_valid <= 1'b1;
    @(posedge core_clk);
    err_f     <= ~f; // Stale fields never linger
    err_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tecc_asserts.sv */
// Port checker for the tag ECC error capture block
`timescale 1ns/1ps
`default_nettype none
module tecc_asserts (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        err_valid,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  reset_state_a: assert property ($fell(rst) |-> avs_waitrequest && !irq
    && avs_readdata == 32'h0) else $error("bad state after reset");
  ans_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  idle_wait_a: assert property (avs_waitrequest && !avs_read && !avs_write
    |=> avs_waitrequest) else $error("answer without request");
  ans_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("request not answered");
  ans_cause_a: assert property (!avs_waitrequest
    |-> $past(avs_read || avs_write)) else $error("stray answer");
  data_hold_a: assert property ($changed(avs_readdata)
    |-> !avs_waitrequest) else $error("read data moved");
  unmap_zero_a: assert property (avs_read && avs_waitrequest
    && $past(avs_waitrequest) && avs_address[1:0] != 2'h0
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  irq_rise_a: assert property ($rose(irq)
    |-> $past(err_valid) || $past(avs_write)) else $error("irq rose alone");
  irq_fall_a: assert property ($fell(irq) |-> $past(avs_write))
    else $error("irq fell alone");
endmodule
bind tecc_packer tecc_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .err_valid(err_valid), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the tag ECC error capture block
`timescale 1ns/1ps
`default_nettype none
module tb
  import tecc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        err_valid;
  logic [33:0] ef;
  int          n_fail = 0;
  int          n_tests = 0;
  initial forever #5 core_clk = ~core_clk;
  tecc_err_src src (.core_clk(core_clk), .err_valid(err_valid), .err_f(ef));
  tecc_packer DUT (.core_clk(core_clk), .rst(rst), .err_valid(err_valid),
    .err_uncorrected(ef[33]), .err_in_data(ef[32]), .err_way(ef[31:28]),
    .err_bank(ef[27]), .err_from_io_unit(ef[26]),
    .err_req_index(ef[25:20]), .err_hart(ef[19:18]), .err_cmd(ef[17:14]),
    .err_group(ef[13:11]), .err_attr(ef[10:8]), .err_size(ef[7:5]),
    .err_ttype(ef[4:1]), .err_sched(ef[0]), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input bit w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [57:0] pack(input logic [33:0] f);
    logic [57:0] d;
    d = 58'h0;
    d[57] = f[32];
    d[29 + f[31:28]] = 1'b1;
    d[28] = f[27];
    d[27:22] = f[26] ? NUM_CORES + f[25:20] : f[25:20];
    d[21:18] = {2'b00, f[19:18]};
    d[17:0] = f[17:0];
    if (f[13:11] == GRP_RESERVED) d[13:11] = GRP_NORMAL;
    if (f[7:5] == SIZE_RSV_32 || f[7:5] == SIZE_RSV_128) d[7:5] = SIZE_64;
    return d;
  endfunction
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
  initial begin
    logic [63:0] mc;
    logic [33:0] f;
    logic [31:0] q;
    logic [1:0]  st;
    logic [1:0]  en;
    logic [1:0]  cl;
    mc = 64'h0;
    st = 2'h0;
    void'($urandom(85294));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    bus(1, ADDR_CAUSE_LO, 32'hffffffff, q);
    bus(0, 4'h2, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    for (int i = 0; i < 60; i++) begin
      en = 2'($urandom);
      bus(1, ADDR_IRQ_EN, {30'h0, en}, q);
      f = {2'($urandom), $urandom};
      f[25:20] = f[26] ? 6'($urandom % 2) : 6'($urandom % 6);
      if (i < 2) begin
        f[13:11] = GRP_RESERVED;
        f[7:5] = i ? SIZE_RSV_128 : SIZE_RSV_32;
        f[31:28] = i ? 4'hf : 4'h0;
      end
      src.fire(f);
      if (mc[63:58] == CLASS_NONE || mc[63:58] == CLASS_CORR)
        mc = {f[33] ? CLASS_UNCR : CLASS_CORR, pack(f)};
      st[f[33]] = 1'b1;
      @(negedge core_clk);
      chk({31'h0, irq}, {31'h0, |(st & en)}, "irq");
      bus(0, ADDR_CAUSE_LO, 32'h0, q);
      chk(q, mc[31:0], "cause low");
      bus(0, ADDR_CAUSE_HI, 32'h0, q);
      chk(q, mc[63:32], "cause high");
      bus(0, ADDR_IRQ_STAT, 32'h0, q);
      chk(q, {30'h0, st}, "status");
      bus(0, ADDR_IRQ_EN, 32'h0, q);
      chk(q, {30'h0, en}, "enable");
      if ($urandom % 3 == 0) begin
        bus(1, ADDR_CAUSE_HI, {mc[63:58], 26'h0}, q);
        mc = 64'h0;
      end
      cl = 2'($urandom);
      bus(1, ADDR_IRQ_CLR, {30'h0, cl}, q);
      st = st & ~cl;
    end
    final_report();
  end
endmodule
`default_nettype wire
